// File: hw/twe_core.sv
// Device-side logic of a three-wire serial EEPROM: instruction parser,
// serial read-out, self-timed programming engine and status output.
// Assumes link pins are asynchronous to clk and far slower than it.
`timescale 1ns/10ps
module twe_core import twe_pkg::*; #(
  parameter int WRITE_CYC = WRITE_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic select,
  input wire logic shift_clock,
  input wire logic serial_in,
  input wire logic organization_strap,
  output logic serial_out,
  output logic serial_out_oe
);
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [3:0] pin_raw, pin_m_q, pin_s_q;
  logic cs_s, sk_s, di_s, org_s, sk_d_q;
  logic sk_rise;
  twe_state_t state_q;
  logic [4:0] cnt_q, hdr_last, dlast;
  logic [11:0] hdr_q;
  logic [12:0] hdr_full;
  logic [1:0] op_w, sub_w, op_q;
  logic [10:0] addr_w, addr_q;
  logic [15:0] dat_q, data_full, wdata;
  logic [3:0] bidx_q;
  logic hdr_done, data_done, read_go, prog_start, start_bit;
  logic l_bulk, l_erase;
  logic [10:0] l_addr;
  logic write_enable_cmd_q, arm_q;
  logic prog_busy_q, pend_q, bulk_q;
  logic [TIMER_W-1:0] timer_q;
  logic [WORD_AW-1:0] walk_q, rd_word;
  logic [1:0] lanes_q;
  logic [15:0] pdata_q, rdata, rdsel;
  logic rd_bit;

  // Reset release through two flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Two-flop synchronisers for every pin; strap resets high so the
  // pad pull-up default of x16 also holds before sampling
  assign pin_raw = {organization_strap, serial_in, shift_clock, select};
  for (genvar g = 0; g < PIN_CNT; g++) begin : g_sync
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        pin_m_q[g] <= PIN_RST[g];
        pin_s_q[g] <= PIN_RST[g];
      end else begin
        pin_m_q[g] <= pin_raw[g];
        pin_s_q[g] <= pin_m_q[g];
      end
    end
  end
  assign cs_s = pin_s_q[0];
  assign sk_s = pin_s_q[1];
  assign di_s = pin_s_q[2];
  assign org_s = pin_s_q[3];

  // Edge detector works on the settled copy only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sk_d_q <= 1'b0;
    end else begin
      sk_d_q <= sk_s;
    end
  end
  assign sk_rise = sk_s & ~sk_d_q;

  // Field layout depends on the strap
  assign hdr_last = org_s ? HDR_LAST_X16 : HDR_LAST_X8;
  assign dlast = org_s ? DATA_LAST_X16 : DATA_LAST_X8;
  assign hdr_full = {hdr_q, di_s};
  assign op_w = org_s ? hdr_full[11:10] : hdr_full[12:11];
  assign sub_w = org_s ? hdr_full[9:8] : hdr_full[10:9];
  assign addr_w = org_s ? {1'b0, hdr_full[9:0]} : hdr_full[10:0];
  assign data_full = {dat_q[14:0], di_s};
  assign wdata = org_s ? data_full : {data_full[7:0], data_full[7:0]};

  // Decode strobes, all qualified by select
  assign start_bit = cs_s && state_q == TWE_START && sk_rise && di_s;
  assign hdr_done = cs_s && state_q == TWE_HDR && sk_rise &&
                    cnt_q == hdr_last;
  assign data_done = cs_s && state_q == TWE_WDATA && sk_rise &&
                     cnt_q == dlast;
  assign read_go = hdr_done && op_w == OP_READ;

  // Launch of a programming cycle, gated by write enable
  assign l_bulk = hdr_done ? (op_w == OP_SPECIAL) : (op_q == OP_SPECIAL);
  assign l_erase = hdr_done;
  assign l_addr = hdr_done ? addr_w : addr_q;
  assign prog_start = write_enable_cmd_q && !prog_busy_q && (data_done ||
    (hdr_done && (op_w == OP_ERASE ||
     (op_w == OP_SPECIAL && sub_w == SUB_ERASE_ALL))));

  // Instruction sequencer; dropping select discards everything
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= TWE_IDLE;
      cnt_q <= 5'h00;
      hdr_q <= 12'h000;
      dat_q <= 16'h0000;
      op_q <= OP_SPECIAL;
      addr_q <= 11'h000;
      bidx_q <= 4'h0;
    end else if (!cs_s) begin
      state_q <= TWE_IDLE;
      cnt_q <= 5'h00;
    end else begin
      case (state_q)
        // Select just rose; busy means status only
        TWE_IDLE: state_q <= prog_busy_q ? TWE_STATUS : TWE_START;
        // Leading zeros are ignored until the start bit
        TWE_START: begin
          if (start_bit) begin
            state_q <= TWE_HDR;
            cnt_q <= 5'h00;
          end
        end
        TWE_HDR: begin
          if (sk_rise) begin
            hdr_q <= hdr_full[11:0];
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == hdr_last) begin
              addr_q <= addr_w;
              op_q <= op_w;
              cnt_q <= 5'h00;
              bidx_q <= dlast[3:0];
              case (op_w)
                OP_READ: state_q <= TWE_READ;
                OP_WRITE: state_q <= TWE_WDATA;
                OP_SPECIAL: state_q <= (sub_w == SUB_WRITE_ALL) ?
                                       TWE_WDATA : TWE_HOLD;
                default: state_q <= TWE_HOLD;
              endcase
            end
          end
        end
        TWE_WDATA: begin
          if (sk_rise) begin
            dat_q <= data_full;
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == dlast) begin
              state_q <= TWE_HOLD;
            end
          end
        end
        // Sequential read rolls into the next location after each word, or after each byte in byte mode
        TWE_READ: begin
          if (sk_rise) begin
            if (bidx_q == 4'h0) begin
              bidx_q <= dlast[3:0];
              addr_q <= org_s ? {1'b0, addr_q[9:0] + 10'h001} :
                                addr_q + 11'h001;
            end else begin
              bidx_q <= bidx_q - 4'h1;
            end
          end
        end
        TWE_STATUS: state_q <= TWE_STATUS;
        TWE_HOLD: state_q <= TWE_HOLD;
        default: state_q <= TWE_IDLE;
      endcase
    end
  end

  // Write-enable state; powers up disabled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      write_enable_cmd_q <= 1'b0;
    end else if (hdr_done && op_w == OP_SPECIAL && !prog_busy_q) begin
      if (sub_w == SUB_WRITE_ENABLE) begin
        write_enable_cmd_q <= 1'b1;
      end else if (sub_w == SUB_WRITE_DISABLE) begin
        write_enable_cmd_q <= 1'b0;
      end
    end
  end

  // Status arming: after a write starts, select shows status
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arm_q <= 1'b0;
    end else if (prog_start) begin
      arm_q <= 1'b1;
    end else if (start_bit) begin
      arm_q <= 1'b0;
    end
  end

  // Self-timed engine: fixed cycle count, bulk ops walk one word a
  // clock, so the walk fits easily inside the timer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_busy_q <= 1'b0;
      pend_q <= 1'b0;
      bulk_q <= 1'b0;
      timer_q <= '0;
      walk_q <= '0;
      lanes_q <= 2'h0;
      pdata_q <= 16'h0000;
    end else if (prog_start) begin
      prog_busy_q <= 1'b1;
      pend_q <= 1'b1;
      bulk_q <= l_bulk;
      timer_q <= TIMER_W'(WRITE_CYC - 1);
      walk_q <= l_bulk ? '0 : (org_s ? l_addr[9:0] : l_addr[10:1]);
      lanes_q <= (l_bulk || org_s) ? 2'h3 : (l_addr[0] ? 2'h1 : 2'h2);
      pdata_q <= l_erase ? ERASED_WORD : wdata;
    end else if (prog_busy_q) begin
      if (pend_q) begin
        if (!bulk_q || walk_q == WORD_AW'(WORDS - 1)) begin
          pend_q <= 1'b0;
        end else begin
          walk_q <= walk_q + 1'b1;
        end
      end
      if (timer_q != '0) begin
        timer_q <= timer_q - 1'b1;
      end else if (!pend_q) begin
        prog_busy_q <= 1'b0;
      end
    end
  end

  // Byte mode reads take the high half at even addresses
  assign rd_word = org_s ? addr_q[9:0] : addr_q[10:1];
  assign rdsel = org_s ? rdata :
                 {8'h00, addr_q[0] ? rdata[7:0] : rdata[15:8]};
  assign rd_bit = rdsel[bidx_q];

  twe_mem #(
    .DEPTH(WORDS),
    .AW(WORD_AW)
  ) u_mem (
    .clk(clk),
    .wr_en(pend_q),
    .wr_lanes(lanes_q),
    .wr_addr(walk_q),
    .wr_data(pdata_q),
    .rd_addr(rd_word),
    .rd_data(rdata)
  );

  // Output pin: status, ready hint, dummy zero, then data MSB first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_out <= 1'b0;
      serial_out_oe <= 1'b0;
    end else if (!cs_s) begin
      serial_out <= 1'b0;
      serial_out_oe <= 1'b0;
    end else if (state_q == TWE_STATUS) begin
      serial_out <= ~prog_busy_q;
      serial_out_oe <= 1'b1;
    end else if (state_q == TWE_START) begin
      serial_out <= 1'b1;
      serial_out_oe <= arm_q;
    end else if (read_go) begin
      serial_out <= 1'b0;
      serial_out_oe <= 1'b1;
    end else if (state_q == TWE_READ) begin
      serial_out_oe <= 1'b1;
      if (sk_rise) begin
        serial_out <= rd_bit;
      end
    end else begin
      serial_out <= 1'b0;
      serial_out_oe <= 1'b0;
    end
  end

  // Busy length counter, read only by the checks below
  logic [TIMER_W-1:0] busy_len_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_len_q <= '0;
    end else if (prog_start) begin
      busy_len_q <= '0;
    end else if (prog_busy_q) begin
      busy_len_q <= busy_len_q + 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  deselect_float_a: assert property (
    !cs_s |=> !serial_out_oe && state_q == TWE_IDLE)
    else $error("output driven while deselected");
  status_busy_a: assert property (
    state_q == TWE_STATUS && cs_s && prog_busy_q |=>
    serial_out_oe && !serial_out)
    else $error("busy status not shown");
  dummy_bit_a: assert property (
    read_go |=> serial_out_oe && !serial_out)
    else $error("dummy zero missing");
  read_data_a: assert property (
    cs_s && state_q == TWE_READ && sk_rise |=> serial_out == $past(rd_bit))
    else $error("read bit mismatch");
  write_gate_a: assert property (
    !write_enable_cmd_q && !prog_busy_q |=> !pend_q)
    else $error("store issued while disabled");
  write_time_a: assert property (
    $fell(prog_busy_q) |-> busy_len_q == TIMER_W'(WRITE_CYC) ||
    WRITE_CYC < WORDS)
    else $error("programming time wrong");
  busy_ignore_a: assert property (
    cs_s && state_q == TWE_IDLE && prog_busy_q |=> state_q == TWE_STATUS)
    else $error("instruction taken while busy");
  start_wait_a: assert property (
    cs_s && state_q == TWE_START && sk_rise && !di_s |=>
    state_q == TWE_START)
    else $error("header began without start bit");
  enable_cmd_a: assert property (
    hdr_done && op_w == OP_SPECIAL && sub_w == SUB_WRITE_ENABLE &&
    !prog_busy_q |=> write_enable_cmd_q)
    else $error("write enable not taken");
  single_write_a: assert property (
    prog_start && !l_bulk |=> pend_q ##1 !pend_q)
    else $error("single write not exactly one store");

  read_seen_c: cover property (read_go);
  erase_all_c: cover property (prog_start && l_bulk && l_erase);
  status_seen_c: cover property (state_q == TWE_STATUS && prog_busy_q);
  write_done_c: cover property ($fell(prog_busy_q));
endmodule

// File: inc/twe_pkg.sv
// Shared constants and types for the three-wire serial EEPROM core.
// Assumes a single 100 MHz system clock samples every link pin.
package twe_pkg;
  // System clock and programming time
  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int WRITE_TIME_MS = 10;
  // Longest time, so integer division rounds down
  localparam int WRITE_CYCLES = WRITE_TIME_MS * (CLK_FREQ_HZ / 1000);
  localparam int TIMER_W = 24;

  // Array geometry: 16384 bits as 1024 x 16 or 2048 x 8
  localparam int TOTAL_BITS = 16384;
  localparam int WORDS = TOTAL_BITS / 16;
  localparam int WORD_AW = 10;
  localparam int BYTE_AW = 11;

  // Header is op code plus address; counts are last-bit indices
  localparam logic [4:0] HDR_LAST_X16 = 5'h0B;
  localparam logic [4:0] HDR_LAST_X8 = 5'h0C;
  localparam logic [4:0] DATA_LAST_X16 = 5'h0F;
  localparam logic [4:0] DATA_LAST_X8 = 5'h07;

  // Operation codes and sub-codes of op code 00
  localparam logic [1:0] OP_SPECIAL = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] SUB_WRITE_DISABLE = 2'h0;
  localparam logic [1:0] SUB_WRITE_ALL = 2'h1;
  localparam logic [1:0] SUB_ERASE_ALL = 2'h2;
  localparam logic [1:0] SUB_WRITE_ENABLE = 2'h3;

  // Value of an erased word
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;

  // Pin synchroniser order and reset levels (strap resets high)
  localparam int PIN_CNT = 4;
  localparam logic [3:0] PIN_RST = 4'h8;

  typedef enum logic [2:0] {
    TWE_IDLE,
    TWE_START,
    TWE_HDR,
    TWE_WDATA,
    TWE_READ,
    TWE_STATUS,
    TWE_HOLD
  } twe_state_t;
endpackage

// File: hw/twe_mem.sv
// Storage array of the EEPROM core, two byte lanes per word.
// Assumes the caller keeps addresses in range; read is combinational.
`timescale 1ns/10ps
module twe_mem #(
  parameter int DEPTH = 1024,
  parameter int AW = 10
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [1:0] wr_lanes,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [15:0] rd_data
);
  // Nonvolatile contents, so no reset on the array
  logic [15:0] mem [DEPTH];

  // Each lane is overwritten in place, no erase step needed; one
  // process owns the whole array, so the two lanes share one writer
  always_ff @(posedge clk) begin
    for (int g = 0; g < 2; g++) begin
      if (wr_en && wr_lanes[g]) begin
        mem[wr_addr][g*8 +: 8] <= wr_data[g*8 +: 8];
      end
    end
  end

  assign rd_data = mem[rd_addr];
endmodule

// File: sim/twe_host.sv
// Host controller model that drives the three-wire link of the core.
// Assumes clk is the core's clock; pins change 1 ns after its rise.
`timescale 1ns/10ps
module twe_host (
  input wire logic clk,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  output logic select,
  output logic shift_clock,
  output logic serial_in
);
  logic line_w;
  // Released line floats, so a stale level can never pass for data
  assign line_w = serial_out_oe ? serial_out : 1'bz;
  initial begin
    select = 1'b0;
    shift_clock = 1'b0;
    serial_in = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One shift period, 5 clk high and 5 clk low, above the 4 clk floor
  task automatic pulse(input logic b);
    serial_in = b;
    wait_clk(1);
    shift_clock = 1'b1;
    wait_clk(5);
    shift_clock = 1'b0;
    wait_clk(4);
  endtask
  // Select rise, n bits MSB first, then nrd sampled read-back bits
  task automatic frame(input logic [63:0] b, input int n, input int nrd,
      output logic [16:0] rd);
    rd = '0;
    select = 1'b1;
    wait_clk(6);
    for (int i = n - 1; i >= 0; i--)
      pulse(b[i]);
    for (int i = 0; i < nrd; i++) begin
      rd = {rd[15:0], line_w};
      pulse(~serial_in);
    end
    select = 1'b0;
    serial_in = ~serial_in;
    wait_clk(6);
  endtask
  // Bare select frame that only samples the status level
  task automatic status(output logic st);
    select = 1'b1;
    wait_clk(8);
    st = line_w;
    select = 1'b0;
    wait_clk(6);
  endtask
endmodule

// File: sim/three_wire_serial_eeprom_core_tb.sv
// Self-checking bench for the three-wire serial EEPROM core.
// Assumes twe_host drives the link; a short write time keeps runs brief.
`timescale 1ns/10ps
module three_wire_serial_eeprom_core_tb;
  import twe_pkg::*;
  localparam int WCYC = 2000;
  logic clk, resetn, strap_en, strap_v, we, st;
  logic select, shift_clock, serial_in, serial_out, serial_out_oe;
  logic [15:0] mem [WORDS];
  logic [16:0] rd;
  logic [15:0] v;
  logic [10:0] a0;
  int error_cnt, compares, seed;
  // Strap pad with a pull-up, released when strap_en is low
  tri1 strap_w;
  assign strap_w = strap_en ? strap_v : 1'bz;
  twe_core #(.WRITE_CYC(WCYC)) uut (.clk(clk), .resetn(resetn),
    .select(select), .shift_clock(shift_clock), .serial_in(serial_in),
    .organization_strap(strap_w), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe));
  twe_host host (.clk(clk), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .select(select),
    .shift_clock(shift_clock), .serial_in(serial_in));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic int aw();
    return (strap_w === 1'b0) ? BYTE_AW : WORD_AW;
  endfunction
  function automatic int dw();
    return (strap_w === 1'b0) ? 8 : 16;
  endfunction
  function automatic logic [15:0] exp_rd(input logic [10:0] a);
    if (strap_w !== 1'b0)
      return mem[a[9:0]];
    return a[0] ? {8'h00, mem[a >> 1][7:0]} : {8'h00, mem[a >> 1][15:8]};
  endfunction
  task automatic put(input logic [10:0] a, input logic [15:0] d);
    if (strap_w !== 1'b0)
      mem[a[9:0]] = d;
    else if (a[0])
      mem[a >> 1][7:0] = d[7:0];
    else
      mem[a >> 1][15:8] = d[7:0];
  endtask
  task automatic check(input string what, input logic [16:0] exp,
      input logic [16:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic send(input logic [1:0] op, input logic [10:0] a,
      input logic [15:0] d, input int nd, input int nrd);
    logic [63:0] b;
    b = {62'h0, op} | 64'h4;
    b = (b << aw()) | (64'(a) & ((64'h1 << aw()) - 1));
    b = (b << nd) | (64'(d) & ((64'h1 << nd) - 1));
    host.frame(b, 3 + aw() + nd, nrd, rd);
  endtask
  // Programming op, then busy, an ignored frame, and a bounded ready poll
  task automatic prog(input logic [1:0] op, input logic [10:0] a,
      input logic [15:0] d, input int nd);
    int n;
    send(op, a, d, nd, 0);
    if (we !== 1'b1)
      return;
    host.status(st);
    check("busy", 17'h0, 17'(st));
    send(OP_WRITE, a, ~d, dw(), 0);
    n = 0;
    do begin
      host.status(st);
      n++;
    end while (st !== 1'b1 && n < 200);
    check("ready", 17'h1, 17'(st));
  endtask
  // Enable and disable start no programming, so no busy poll follows
  task automatic spec(input logic [1:0] sub, input logic [15:0] d,
      input int nd);
    if (sub == SUB_WRITE_ENABLE || sub == SUB_WRITE_DISABLE)
      send(OP_SPECIAL, 11'(sub) << (aw() - 2), d, nd, 0);
    else
      prog(OP_SPECIAL, 11'(sub) << (aw() - 2), d, nd);
  endtask
  task automatic rdchk(input logic [10:0] a);
    send(OP_READ, a, 16'h0000, 0, dw() + 1);
    check("read", 17'(exp_rd(a)), rd);
  endtask
  task automatic wr(input logic [10:0] a, input logic [15:0] d);
    prog(OP_WRITE, a, d, dw());
    if (we === 1'b1)
      put(a, d);
  endtask
  task automatic summarize();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog sized well above the roughly 25k cycles the tests need
  initial begin
    #900_000;
    error_cnt++;
    summarize();
  end
  initial begin
    resetn = 1'b0;
    strap_en = 1'b0;
    strap_v = 1'b1;
    we = 1'b0;
    error_cnt = 0;
    compares = 0;
    seed = 11;
    repeat (2) @(posedge clk);
    #1 resetn = 1'b1;
    host.wait_clk(8);
    check("oe_idle", 17'h0, 17'(serial_out_oe));
    $display("test reset done");
    // Floating strap means word mode; random word writes and overwrites
    a0 = 11'($random(seed)) & 11'h3FF;
    we = 1'b1;
    spec(SUB_WRITE_ENABLE, 16'h0000, 0);
    for (int i = 0; i < 3; i++) begin
      v = 16'($random(seed));
      wr(a0, v);
      rdchk(a0);
    end
    wr(11'h3FF, 16'h0000);
    rdchk(11'h3FF);
    $display("test word write done");
    // Partial instruction dropped by select low, then a clean read
    host.frame(64'h0D, 5, 0, rd);
    rdchk(a0);
    prog(OP_ERASE, a0, 16'h0000, 0);
    put(a0, 16'hFFFF);
    rdchk(a0);
    spec(SUB_WRITE_DISABLE, 16'h0000, 0);
    we = 1'b0;
    wr(a0, 16'h1234);
    rdchk(a0);
    $display("test erase and disable done");
    // Byte mode with the strap driven low
    strap_en = 1'b1;
    strap_v = 1'b0;
    host.wait_clk(6);
    we = 1'b1;
    spec(SUB_WRITE_ENABLE, 16'h0000, 0);
    v = 16'($random(seed));
    wr(11'h7FF, v);
    wr(11'h7FE, ~v);
    rdchk(11'h7FF);
    rdchk(11'h7FE);
    // Sequential read runs on into the next byte with no second dummy
    send(OP_READ, 11'h7FE, 16'h0000, 0, 17);
    check("seq_read", 17'({~v[7:0], v[7:0]}), rd);
    spec(SUB_WRITE_ALL, {8'h00, v[15:8]}, 8);
    for (int i = 0; i < WORDS; i++)
      mem[i] = {v[15:8], v[15:8]};
    rdchk(11'($random(seed)));
    $display("test byte mode done");
    // Erase-all seen back in word mode
    spec(SUB_ERASE_ALL, 16'h0000, 0);
    for (int i = 0; i < WORDS; i++)
      mem[i] = ERASED_WORD;
    strap_v = 1'b1;
    host.wait_clk(6);
    rdchk(11'h000);
    $display("test bulk done");
    summarize();
  end
endmodule
